// File: logic/iem_defines.vh
// register map and constants of the interrupt enable mask block
`ifndef IEM_DEFINES_VH
`define IEM_DEFINES_VH

// ----------------------------------------------------------------
// special-function registers
// ----------------------------------------------------------------
`define IEM_MASK_ADDR      8'ha8
`define IEM_MASK_RESET     8'h00
`define IEM_PRIO_ADDR      8'hb8
`define IEM_PRIO_RESET     8'h80

// ----------------------------------------------------------------
// enable register fields
// ----------------------------------------------------------------
`define IEM_BIT_EXT0       0
`define IEM_BIT_TMR0       1
`define IEM_BIT_EXT1       2
`define IEM_BIT_TMR1       3
`define IEM_BIT_UART       4
`define IEM_BIT_TMR2       5
`define IEM_BIT_SPER       6
`define IEM_BIT_GLOBAL     7

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define IEM_NUM_SRC        7
`define IEM_IDX_W          3
`define IEM_NO_SRC         3'h7

`endif

// File: logic/iem_prio_pick.v
// fixed-order two-level arbiter over the masked requests
`timescale 1ns/10ps
`default_nettype none
`include "iem_defines.vh"

module iem_prio_pick #(
  parameter NSRC = `IEM_NUM_SRC
) (
  input  wire [NSRC-1:0]       reqMasked,
  input  wire [NSRC-1:0]       prioHigh,
  output reg                   anyReq,
  output reg                   pickHigh,
  output reg  [`IEM_IDX_W-1:0] pickIdx
);

  // ----------------------------------------------------------------
  // lowest set index, or the none code
  // ----------------------------------------------------------------
  function [`IEM_IDX_W:0] firstSet;
    input [NSRC-1:0] vec;
    integer i;
    begin
      firstSet = {1'b0, `IEM_NO_SRC};
      for (i = NSRC - 1; i >= 0; i = i - 1) begin
        if (vec[i]) begin
          firstSet = {1'b1, i[`IEM_IDX_W-1:0]};
        end
      end
    end
  endfunction

  reg [`IEM_IDX_W:0] hiPick;
  reg [`IEM_IDX_W:0] loPick;

  always @* begin
    hiPick = firstSet(reqMasked & prioHigh);
    loPick = firstSet(reqMasked & ~prioHigh);
    // high level beats low; within a level the lower index wins
    if (hiPick[`IEM_IDX_W]) begin
      anyReq   = 1'b1;
      pickHigh = 1'b1;
      pickIdx  = hiPick[`IEM_IDX_W-1:0];
    end else begin
      anyReq   = loPick[`IEM_IDX_W];
      pickHigh = 1'b0;
      pickIdx  = loPick[`IEM_IDX_W-1:0];
    end
  end

endmodule
`default_nettype wire

// File: logic/iem_interrupt_enable_mask.v
// interrupt enable mask and priority registers with masked request decode
//
// Notes on behaviour
// - global enable low blocks every request
// - global high passes only individually enabled sources
// - eight-bit enable register, resets to zero
// - separate priority register, independent of enables
// - masked requests sampled and decoded every cycle
// - still-pending flag re-requests right after return
// - equal level ties resolved by lowest index
`timescale 1ns/10ps
`default_nettype none
`include "iem_defines.vh"

module iem_interrupt_enable_mask #(
  parameter NSRC = `IEM_NUM_SRC
) (
  input  wire                   clk,
  input  wire                   rstn,
  input  wire [7:0]             sfrAddr,
  input  wire [7:0]             sfrWdata,
  input  wire                   sfrWe,
  input  wire                   sfrRe,
  output reg  [7:0]             sfrRdata,
  output reg                    sfrHit,
  input  wire                   ext_pin_zero_request,
  input  wire                   timer_zero_overflow_flag,
  input  wire                   ext_pin_one_request,
  input  wire                   timer_one_overflow_flag,
  input  wire                   uartPending,
  input  wire                   timer_two_low_overflow_flag,
  input  wire                   timer_two_high_overflow_flag,
  input  wire                   serialPeriphPending,
  input  wire                   return_from_interrupt,
  output wire                   global_irq_enable,
  output reg  [NSRC-1:0]        maskedReq,
  output reg                    irqRequest,
  output reg                    irqHighLevel,
  output reg  [`IEM_IDX_W-1:0]  irqIndex
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg rstSync1;
  reg rstSync2;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end
  wire rstnInt = rstSync2;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // one compare shared by the write and the read decode
  function addrHit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addrHit = (addr == target);
    end
  endfunction

  // unmapped addresses read back as zero, never as stale data
  function [7:0] readMux;
    input       selMask;
    input       selPrio;
    input [7:0] maskVal;
    input [7:0] prioVal;
    begin
      if (selMask) begin
        readMux = maskVal;
      end else if (selPrio) begin
        readMux = prioVal;
      end else begin
        readMux = 8'h00;
      end
    end
  endfunction

  // all-zero unless the global bit is set
  function [NSRC-1:0] gateReq;
    input            gbl;
    input [NSRC-1:0] raw;
    input [NSRC-1:0] en;
    begin
      if (gbl) begin
        gateReq = raw & en;
      end else begin
        gateReq = {NSRC{1'b0}};
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [7:0] enableMask_reg;
  reg  [7:0] priority_reg;
  wire       hitMask = addrHit(sfrAddr, `IEM_MASK_ADDR);
  wire       hitPrio = addrHit(sfrAddr, `IEM_PRIO_ADDR);

  always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      enableMask_reg <= `IEM_MASK_RESET;
    end else if (sfrWe & hitMask) begin
      enableMask_reg <= sfrWdata;
    end
  end

  // kept apart from the mask so the two settings never interact
  always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      priority_reg <= `IEM_PRIO_RESET;
    end else if (sfrWe & hitPrio) begin
      // top bit is unused and always reads one
      priority_reg <= {1'b1, sfrWdata[6:0]};
    end
  end

  always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      sfrHit <= 1'b0;
    end else begin
      sfrHit <= sfrRe & (hitMask | hitPrio);
    end
  end

  // a write in the same cycle as a read is seen only by the next read
  always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      sfrRdata <= 8'h00;
    end else begin
      sfrRdata <= readMux(sfrRe & hitMask, sfrRe & hitPrio, enableMask_reg, priority_reg);
    end
  end

  // ----------------------------------------------------------------
  // named enable fields
  // ----------------------------------------------------------------
  assign global_irq_enable = enableMask_reg[`IEM_BIT_GLOBAL];
  wire ext_pin_zero_irq_enable  = enableMask_reg[`IEM_BIT_EXT0];
  wire timer_zero_irq_enable    = enableMask_reg[`IEM_BIT_TMR0];
  wire ext_pin_one_irq_enable   = enableMask_reg[`IEM_BIT_EXT1];
  wire timer_one_irq_enable     = enableMask_reg[`IEM_BIT_TMR1];
  wire uart_irq_enable          = enableMask_reg[`IEM_BIT_UART];
  wire timer_two_irq_enable     = enableMask_reg[`IEM_BIT_TMR2];
  wire serial_periph_irq_enable = enableMask_reg[`IEM_BIT_SPER];

  // ----------------------------------------------------------------
  // masking; pending inputs are levels from same-clock logic
  // ----------------------------------------------------------------
  wire [NSRC-1:0] rawReq = {
    serialPeriphPending,
    timer_two_low_overflow_flag | timer_two_high_overflow_flag,
    uartPending,
    timer_one_overflow_flag,
    ext_pin_one_request,
    timer_zero_overflow_flag,
    ext_pin_zero_request
  };

  wire [NSRC-1:0] srcEnable = {
    serial_periph_irq_enable,
    timer_two_irq_enable,
    uart_irq_enable,
    timer_one_irq_enable,
    ext_pin_one_irq_enable,
    timer_zero_irq_enable,
    ext_pin_zero_irq_enable
  };

  // global bit overrides every per-source bit
  wire [NSRC-1:0] gatedReq = gateReq(global_irq_enable, rawReq, srcEnable);

  wire                  anyReq;
  wire                  pickHigh;
  wire [`IEM_IDX_W-1:0] pickIdx;

  iem_prio_pick #(
    .NSRC (NSRC)
  ) uPick (
    .reqMasked (gatedReq),
    .prioHigh  (priority_reg[NSRC-1:0]),
    .anyReq    (anyReq),
    .pickHigh  (pickHigh),
    .pickIdx   (pickIdx)
  );

  // ----------------------------------------------------------------
  // decode stage, refreshed every cycle
  // ----------------------------------------------------------------
  // no hold-off after return: a flag still pending simply re-requests
  // on the next sample, which the core turns into re-entry
  always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      maskedReq    <= {NSRC{1'b0}};
      irqRequest   <= 1'b0;
    end else begin
      maskedReq    <= gatedReq;
      irqRequest   <= anyReq;
    end
  end

  // winner index and its level travel with the request of the same cycle
  always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      irqHighLevel <= 1'b0;
      irqIndex     <= `IEM_NO_SRC;
    end else begin
      irqHighLevel <= pickHigh;
      irqIndex     <= pickIdx;
    end
  end

  // return pulse is informational here; request stays level-driven
  wire unusedRet = return_from_interrupt;

endmodule
`default_nettype wire

// File: dv/iem_mask_chk.sv
// port checker of the interrupt enable mask block
`timescale 1ns/10ps
`default_nettype none
module iem_mask_chk #(parameter NSRC = 7) (
  input wire logic            clk,
  input wire logic            rstn,
  input wire logic [7:0]      sfrAddr,
  input wire logic [7:0]      sfrWdata,
  input wire logic            sfrWe,
  input wire logic            sfrRe,
  input wire logic [7:0]      sfrRdata,
  input wire logic            sfrHit,
  input wire logic            ext_pin_zero_request,
  input wire logic            timer_zero_overflow_flag,
  input wire logic            ext_pin_one_request,
  input wire logic            timer_one_overflow_flag,
  input wire logic            uartPending,
  input wire logic            timer_two_low_overflow_flag,
  input wire logic            timer_two_high_overflow_flag,
  input wire logic            serialPeriphPending,
  input wire logic            global_irq_enable,
  input wire logic [NSRC-1:0] maskedReq,
  input wire logic            irqRequest,
  input wire logic            irqHighLevel,
  input wire logic [2:0]      irqIndex
);
  // timer two flags share one source
  wire [NSRC-1:0] pend = {serialPeriphPending, timer_two_low_overflow_flag | timer_two_high_overflow_flag,
    uartPending, timer_one_overflow_flag, ext_pin_one_request, timer_zero_overflow_flag, ext_pin_zero_request};
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_maskWr; sfrWe && sfrAddr == 8'ha8; endsequence
  sequence s_maskRd; sfrRe && sfrAddr == 8'ha8; endsequence
  property p_gblOff; !$past(global_irq_enable) |-> maskedReq == '0; endproperty
  a_gblOff: assert property (p_gblOff) else $error("request passed while disabled");
  property p_gate; (maskedReq & ~$past(pend)) == '0; endproperty
  a_gate: assert property (p_gate) else $error("request without pending source");
  property p_rd; s_maskRd |=> sfrHit && sfrRdata[7] == $past(global_irq_enable); endproperty
  a_rd: assert property (p_rd) else $error("mask read wrong");
  property p_wr; s_maskWr |=> global_irq_enable == $past(sfrWdata[7]); endproperty
  a_wr: assert property (p_wr) else $error("mask write lost");
  property p_unmap; sfrRe && sfrAddr != 8'ha8 && sfrAddr != 8'hb8 |=> !sfrHit && sfrRdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read answered");
  property p_any; irqRequest == (maskedReq != '0); endproperty
  a_any: assert property (p_any) else $error("request line disagrees");
  property p_none; !irqRequest |-> irqIndex == 3'h7; endproperty
  a_none: assert property (p_none) else $error("index without request");
  property p_tie; irqRequest && !irqHighLevel |->
    maskedReq[irqIndex] && (maskedReq & ~({NSRC{1'b1}} << irqIndex)) == '0; endproperty
  a_tie: assert property (p_tie) else $error("tie not lowest index");
  property p_hiWin; irqRequest && irqHighLevel |-> maskedReq[irqIndex]; endproperty
  a_hiWin: assert property (p_hiWin) else $error("high winner not pending");
endmodule
bind iem_interrupt_enable_mask iem_mask_chk #(.NSRC(NSRC)) u_chk (.*);
`default_nettype wire

// File: dv/iem_core_model.sv
// behavioural core that services requests and returns
`timescale 1ns/10ps
`default_nettype none
module iem_core_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic irqRequest,
  output var logic  return_from_interrupt
);
  logic [3:0] svcCount_reg;
  logic       slow_reg;
  // service time alternates so returns come both promptly and late
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      svcCount_reg <= 4'h0;
      slow_reg <= 1'b0;
      return_from_interrupt <= 1'b0;
    end else begin
      return_from_interrupt <= svcCount_reg == 4'h1;
      if (svcCount_reg != 4'h0)
        svcCount_reg <= svcCount_reg - 4'h1;
      else if (irqRequest) begin
        svcCount_reg <= slow_reg ? 4'h9 : 4'h2;
        slow_reg <= !slow_reg;
      end
    end
  end
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// random self-checking bench of the enable mask block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic       clk = 1'b0;
  logic       rstn;
  logic [7:0] sfrAddr = 8'h00;
  logic [7:0] sfrWdata = 8'h00;
  logic       sfrWe = 1'b0;
  logic       sfrRe = 1'b0;
  logic [7:0] pend = 8'h00;
  wire        ext_pin_zero_request = pend[0];
  wire        timer_zero_overflow_flag = pend[1];
  wire        ext_pin_one_request = pend[2];
  wire        timer_one_overflow_flag = pend[3];
  wire        uartPending = pend[4];
  wire        timer_two_low_overflow_flag = pend[5];
  wire        timer_two_high_overflow_flag = pend[6];
  wire        serialPeriphPending = pend[7];
  wire        return_from_interrupt;
  wire [7:0]  sfrRdata;
  wire        sfrHit;
  wire        global_irq_enable;
  wire [6:0]  maskedReq;
  wire        irqRequest;
  wire        irqHighLevel;
  wire [2:0]  irqIndex;
  integer     seed = 34;
  integer     failures = 0;
  integer     checks_done = 0;
  integer     i;
  integer     k;
  logic [7:0] m = 8'h00;
  logic [7:0] pr = 8'h80;
  logic [7:0] eRd;
  logic [6:0] eMr;
  logic [2:0] eIdx;
  logic       eHi;
  logic       eHit;
  iem_interrupt_enable_mask dut (.*);
  iem_core_model core (.*);
  always #10 clk = ~clk;
  task chk(input [8:0] seen, input [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task results;
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // the second call comes mid-run, so reset values are read back again
  task doReset;
    rstn = 1'b0;
    m = 8'h00;
    pr = 8'h80;
    repeat (10) @(posedge clk);
    #1;
    sfrRe = 1'b0;
    sfrWe = 1'b0;
    rstn = 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // ------------------------------------------------------------
  // random traffic against the reference model
  // ------------------------------------------------------------
  initial begin
    for (i = 0; i < 3000; i++) begin
      if (i % 1500 == 0)
        doReset();
      @(posedge clk);
      #1;
      if (i % 1500 > 0) begin
        chk(9'(maskedReq), 9'(eMr));
        chk(9'(irqRequest), 9'(|eMr));
        chk(9'(irqIndex), 9'(eIdx));
        chk(9'(irqHighLevel), 9'(eHi));
        chk(9'(global_irq_enable), 9'(m[7]));
        chk({sfrHit, sfrRdata}, {eHit, eRd});
      end
      pend = 8'($random(seed));
      sfrRe = i % 1500 < 2 || ($random(seed) & 3) == 0;
      k = $random(seed) & 3;
      sfrAddr = i % 1500 < 2 ? (i % 2 ? 8'hb8 : 8'ha8) : k == 0 ? 8'ha8 : k == 1 ? 8'hb8 : 8'($random(seed));
      sfrWe = i % 1500 > 1 && ($random(seed) & 7) == 0;
      sfrWdata = 8'($random(seed));
      eMr = m[7] ? {pend[7], pend[6] | pend[5], pend[4:0]} & m[6:0] : 7'h00;
      eHi = |(eMr & pr[6:0]);
      eIdx = 3'h7;
      for (k = 6; k >= 0; k--)
        if (eMr[k] && (pr[k] || !eHi)) eIdx = k[2:0];
      eHit = sfrRe && (sfrAddr == 8'ha8 || sfrAddr == 8'hb8);
      eRd = !eHit ? 8'h00 : sfrAddr == 8'ha8 ? m : pr;
      if (sfrWe && sfrAddr == 8'ha8) m = sfrWdata;
      if (sfrWe && sfrAddr == 8'hb8) pr = {1'b1, sfrWdata[6:0]};
    end
    results();
  end
  // the run needs some 60.5 us; a hang is cut off well after that
  initial begin
    #100000;
    failures++;
    results();
  end
endmodule
`default_nettype wire
